/* File: rtl/gpio_alarm_consts.svh */
// constants for the accessory line control and alarm block
`ifndef GPIO_ALARM_CONSTS_SVH
`define GPIO_ALARM_CONSTS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_POL 8'h04
`define ADDR_STAT 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_MAJOR 8'h14
`define ADDR_MINOR 8'h18
`define LOCK_COUNT 2'h3
`define DEBOUNCE_NS 1000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS + 7) / 8)
`define POL_RESET 8'h00
`define POL_DIS_BIT 0
`define POL_PWR_BIT 1
`define POL_KD_BIT 2
`define POL_CH_LSB 3
`define POL_MAJ_BIT 7
`define POL_MIN_BIT 8
`define IRQ_LOCK_BIT 0
`define IRQ_MINOR_BIT 1
`define IRQ_MAJOR_BIT 2
`define IRQ_CH_BIT 3
`endif

/* File: rtl/gpio_alarm_pkg.sv */
// types shared by the accessory line control and alarm block
package gpio_alarm_pkg;
  typedef enum logic [1:0] {RUN, LOCKED} lock_e;
endpackage

/* File: rtl/line_filter.sv */
// two-stage synchroniser and debounce for one input line
`timescale 1ns/1ps
`include "gpio_alarm_consts.svh"
module line_filter #(
  parameter int CYCLES = `DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // line
  input wire logic line_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [15:0] cnt;
  } st_s;
  st_s st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = line_i;
    st_next.s2 = st_reg.s1;
    // only s2 is looked at; s1 feeds nothing else
    if (st_reg.s2 == st_reg.lvl) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt >= 16'(CYCLES - 1)) begin
      st_next.lvl = st_reg.s2;
      st_next.cnt = 16'h0000;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_o = st_reg.lvl;
endmodule

/* File: rtl/repeater_gpio_alarm_control.sv */
// accessory port control lines, alarm outputs and register slave
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "gpio_alarm_consts.svh"
module repeater_gpio_alarm_control #(
  parameter int NCH = 4,
  parameter int DEB_CYCLES = `DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // accessory input lines, level only
  input wire logic disable_line_i,
  input wire logic power_line_i,
  input wire logic knockdown_line_i,
  input wire logic [NCH-1:0] chan_line_i,
  // repeater status
  input wire logic major_alarm_i,
  input wire logic minor_alarm_i,
  input wire logic chan_digital_i,
  input wire logic digital_tx_i,
  // alarm output lines
  output logic major_line_o,
  output logic minor_line_o,
  // control outcome
  output logic disabled_o,
  output logic high_power_o,
  output logic knockdown_o,
  output logic [NCH-1:0] channel_o,
  output logic reset_req_o,
  output logic locked_o,
  output logic irq_o
);
  localparam int NIN = NCH + 3;
  typedef struct packed {
    logic [8:0] pol;
    logic [1:0] count;
    gpio_alarm_pkg::lock_e lock;
    logic major_d;
    logic reset_req;
    logic minor_d;
    logic [NCH-1:0] chan_d;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic dis;
    logic pwr;
    logic kd;
    logic [NCH-1:0] ch;
    logic maj_o;
    logic min_o;
  } st_s;
  st_s st_reg, st_next;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] filt;
  logic bus_req;
  function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] wr,
                                     input logic [3:0] ev);
    // a set in the clearing cycle wins
    w1c = (cur & ~wr) | ev;
  endfunction
  assign raw = {chan_line_i, knockdown_line_i, power_line_i, disable_line_i};
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_in
      line_filter #(.CYCLES(DEB_CYCLES)) u_f (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(raw[g]),
        .level_o(filt[g])
      );
    end
  endgenerate
  wb_regs u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_o),
    .req_o(bus_req)
  );
  logic dis_a, pwr_a, kd_a;
  logic [NCH-1:0] ch_a;
  logic wr, lock_clr;
  logic [3:0] ev, wclr;
  always_comb begin
    st_next = st_reg;
    dis_a = filt[0] ^ st_reg.pol[`POL_DIS_BIT];
    pwr_a = filt[1] ^ st_reg.pol[`POL_PWR_BIT];
    kd_a = filt[2] ^ st_reg.pol[`POL_KD_BIT];
    ch_a = filt[NIN-1:3] ^ st_reg.pol[`POL_CH_LSB +: NCH];
    wr = bus_req && we_i;
    lock_clr = wr && adr_i == `ADDR_STAT && sel_i[0] && dat_i[0];
    wclr = (wr && adr_i == `ADDR_IRQ_STAT && sel_i[0]) ? dat_i[3:0] : 4'h0;
    st_next.major_d = major_alarm_i;
    st_next.minor_d = minor_alarm_i;
    st_next.chan_d = st_reg.ch;
    st_next.reset_req = 1'b0;
    ev = 4'h0;
    // each new major alarm while running is counted; the first two ask for a reset, the third locks instead
    if (major_alarm_i && !st_reg.major_d && st_reg.lock == gpio_alarm_pkg::RUN) begin
      ev[`IRQ_MAJOR_BIT] = 1'b1;
      if (st_reg.count == `LOCK_COUNT - 2'h1) begin
        st_next.count = `LOCK_COUNT;
        st_next.lock = gpio_alarm_pkg::LOCKED;
        ev[`IRQ_LOCK_BIT] = 1'b1;
      end else begin
        st_next.count = st_reg.count + 2'h1;
        st_next.reset_req = 1'b1;
      end
    end
    if (lock_clr) begin
      st_next.count = 2'h0;
      st_next.lock = gpio_alarm_pkg::RUN;
      st_next.reset_req = 1'b1;
    end
    ev[`IRQ_MINOR_BIT] = minor_alarm_i && !st_reg.minor_d;
    ev[`IRQ_CH_BIT] = st_reg.ch != st_reg.chan_d;
    // line controls still act under minor alarm; only radio activity stops
    st_next.dis = dis_a || minor_alarm_i || st_next.lock == gpio_alarm_pkg::LOCKED;
    st_next.pwr = pwr_a;
    st_next.kd = kd_a && !chan_digital_i && !digital_tx_i;
    st_next.ch = ch_a;
    // alarm lines are plain outputs; input pins are never driven
    st_next.maj_o = (st_next.lock == gpio_alarm_pkg::LOCKED) ^ st_reg.pol[`POL_MAJ_BIT];
    st_next.min_o = minor_alarm_i ^ st_reg.pol[`POL_MIN_BIT];
    st_next.irq_stat = w1c(st_reg.irq_stat, wclr, ev);
    if (wr && adr_i == `ADDR_POL) begin
      if (sel_i[0]) st_next.pol[7:0] = dat_i[7:0];
      if (sel_i[1]) st_next.pol[8] = dat_i[8];
    end
    if (wr && adr_i == `ADDR_IRQ_MASK && sel_i[0]) st_next.irq_mask = dat_i[3:0];
    st_next.rdata = 32'h0000_0000;
    unique case (adr_i)
      `ADDR_CTRL: st_next.rdata = 32'({st_reg.ch, st_reg.kd, st_reg.pwr, st_reg.dis});
      `ADDR_POL: st_next.rdata = 32'(st_reg.pol);
      `ADDR_STAT: st_next.rdata = 32'({st_reg.count, st_reg.lock == gpio_alarm_pkg::LOCKED});
      `ADDR_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_stat);
      `ADDR_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
      `ADDR_MAJOR: st_next.rdata = 32'(st_reg.maj_o);
      `ADDR_MINOR: st_next.rdata = 32'(st_reg.min_o);
      default: st_next.rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.pol <= 9'(`POL_RESET);
    end else begin
      st_reg <= st_next;
    end
  end
  assign dat_o = st_reg.rdata;
  assign major_line_o = st_reg.maj_o;
  assign minor_line_o = st_reg.min_o;
  assign disabled_o = st_reg.dis;
  assign high_power_o = st_reg.pwr;
  assign knockdown_o = st_reg.kd;
  assign channel_o = st_reg.ch;
  assign reset_req_o = st_reg.reset_req;
  assign locked_o = st_reg.lock == gpio_alarm_pkg::LOCKED;
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // pin level is launched with the polarity of the previous cycle
  lock_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    major_line_o == (locked_o ^ $past(st_reg.pol[`POL_MAJ_BIT])))
    else $error("major line does not follow lock");
  third_major_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.count == 2'h2 && major_alarm_i && !st_reg.major_d && !lock_clr && !locked_o
    |=> locked_o && !reset_req_o)
    else $error("third major alarm did not lock");
  minor_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
    minor_alarm_i |=> minor_line_o == !$past(st_reg.pol[`POL_MIN_BIT]))
    else $error("minor line not asserted");
  minor_dis_a: assert property (@(posedge clk_i) disable iff (rst_i)
    minor_alarm_i |=> disabled_o)
    else $error("minor alarm did not disable");
  kd_digital_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chan_digital_i |=> !knockdown_o)
    else $error("knockdown in digital mode");
  kd_dtx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    digital_tx_i |=> !knockdown_o)
    else $error("knockdown during digital transmit");
  unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_clr |=> !locked_o && reset_req_o && st_reg.count == 2'h0)
    else $error("lock not removed");
  chan_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> channel_o == $past(filt[NIN-1:3] ^ st_reg.pol[`POL_CH_LSB +: NCH]))
    else $error("channel index wrong");
  power_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[1] != st_reg.pol[`POL_PWR_BIT] |=> high_power_o)
    else $error("power level wrong");

  // line controls, one cycle after the filtered level
  dis_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[0] != st_reg.pol[`POL_DIS_BIT] |=> disabled_o)
    else $error("disable input ignored");

  enable_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[0] == st_reg.pol[`POL_DIS_BIT] && !minor_alarm_i && st_next.lock == gpio_alarm_pkg::RUN
    |=> !disabled_o)
    else $error("unit not enabled after release");

  lock_dis_a: assert property (@(posedge clk_i) disable iff (rst_i)
    locked_o |-> disabled_o)
    else $error("locked unit still repeating");

  power_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[1] == st_reg.pol[`POL_PWR_BIT] |=> !high_power_o)
    else $error("power not back to low");

  kd_norm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[2] != st_reg.pol[`POL_KD_BIT] && !chan_digital_i && !digital_tx_i |=> knockdown_o)
    else $error("knockdown input ignored");

  kd_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    filt[2] == st_reg.pol[`POL_KD_BIT] |=> !knockdown_o)
    else $error("knockdown held after release");

  // alarm counting and lock, minor alarm line and event
  reset_major_a: assert property (@(posedge clk_i) disable iff (rst_i)
    major_alarm_i && !st_reg.major_d && !locked_o && st_reg.count < 2'h2 && !lock_clr
    |=> reset_req_o && !locked_o)
    else $error("major alarm gave no reset");

  lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    locked_o && !lock_clr |=> locked_o)
    else $error("lock dropped without clear");

  count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(major_alarm_i && !st_reg.major_d) && !lock_clr |=> $stable(st_reg.count))
    else $error("alarm count moved by itself");

  no_lock_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !locked_o && st_reg.count < 2'h2 && !lock_clr |=> !locked_o)
    else $error("locked before third alarm");

  unlock_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_clr && !minor_alarm_i && filt[0] == st_reg.pol[`POL_DIS_BIT] |=> !disabled_o)
    else $error("unit not running after unlock");

  minor_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !minor_alarm_i |=> minor_line_o == $past(st_reg.pol[`POL_MIN_BIT]))
    else $error("minor line asserted without alarm");

  minor_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    minor_alarm_i && !st_reg.minor_d |=> st_reg.irq_stat[`IRQ_MINOR_BIT])
    else $error("minor alarm event lost");

  // register slave: polarity set is written and answered in one cycle
  pol_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == `ADDR_POL && sel_i[0] |=> st_reg.pol[7:0] == $past(dat_i[7:0]))
    else $error("polarity write lost");

  ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus access not acknowledged");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
endmodule

/* File: rtl/wb_regs.sv */
// classic wishbone slave handshake helper: one-cycle ack and access request, no address decode
`timescale 1ns/1ps
module wb_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic req_o
);
  typedef struct packed {
    logic ack;
  } st_s;
  st_s st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.ack = cyc_i && stb_i && !st_reg.ack;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ack_o = st_reg.ack;
  // access takes effect at the acking edge
  assign req_o = cyc_i && stb_i && !st_reg.ack;
endmodule

/* File: tb/console_model.sv */
// outside console model driving the accessory input pins
`timescale 1ns/1ps
module console_model (
  // asserted requests and wiring polarity, 1 = active low
  input wire logic [6:0] want_i,
  input wire logic [6:0] low_i,
  // pins seen by the unit
  output logic [6:0] pin_o
);
  // pin level is owned out here, the unit only reads it
  assign pin_o = want_i ^ low_i;
endmodule

/* File: tb/test_repeater_gpio_alarm_control.sv */
// self-checking bench for the accessory line control block
`timescale 1ns/1ps
`include "gpio_alarm_consts.svh"
module test_repeater_gpio_alarm_control;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, dat_o, q;
  logic ack_o, maj = 0, mnr = 0, dig = 0, dtx = 0;
  logic [6:0] want = 7'h00, low = 7'h00, pin;
  logic major_line_o, minor_line_o, disabled_o, high_power_o, knockdown_o;
  logic [3:0] channel_o;
  logic reset_req_o, locked_o, irq_o;
  int errors = 0, check_count = 0, pulses = 0;
  always #4 clk_i = ~clk_i;
  console_model i_console_model (.want_i(want), .low_i(low), .pin_o(pin));
  repeater_gpio_alarm_control #(.NCH(4), .DEB_CYCLES(2)) i_repeater_gpio_alarm_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .disable_line_i(pin[0]), .power_line_i(pin[1]), .knockdown_line_i(pin[2]),
    .chan_line_i(pin[6:3]), .major_alarm_i(maj), .minor_alarm_i(mnr),
    .chan_digital_i(dig), .digital_tx_i(dtx), .major_line_o(major_line_o),
    .minor_line_o(minor_line_o), .disabled_o(disabled_o), .high_power_o(high_power_o),
    .knockdown_o(knockdown_o), .channel_o(channel_o), .reset_req_o(reset_req_o),
    .locked_o(locked_o), .irq_o(irq_o));
  always @(posedge clk_i) if (reset_req_o === 1'b1) pulses++;
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin errors++; results(); end
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  // covers the two-stage sync plus debounce with margin
  task automatic settle();
    repeat (12) @(posedge clk_i);
  endtask
  task automatic t_lines();
    want <= {4'hA, 3'b011}; settle();
    chk(disabled_o, 1);
    chk(high_power_o, 1);
    chk(channel_o, 4'hA);
    wb(0, `ADDR_CTRL, 0); chk(q, 32'h0000_0053);
    want <= {4'hF, 3'b000}; settle();
    chk(channel_o, 4'hF);
    chk({disabled_o, high_power_o}, 0);
    want <= 7'h00; settle();
    chk(channel_o, 0);
  endtask
  task automatic t_pol();
    wb(1, `ADDR_POL, 32'h0000_01FF); low <= 7'h7F; want <= 7'h01; settle();
    chk(disabled_o, 1);
    chk({major_line_o, minor_line_o}, 2'b11);
    wb(0, `ADDR_POL, 0); chk(q, 32'h0000_01FF);
    want <= 7'h00; low <= 7'h00; wb(1, `ADDR_POL, 0); settle();
    chk({disabled_o, major_line_o, minor_line_o}, 0);
  endtask
  task automatic t_knock();
    want <= 7'h04; settle();
    chk(knockdown_o, 1);
    dig <= 1; repeat (3) @(posedge clk_i);
    chk(knockdown_o, 0);
    dig <= 0; dtx <= 1; repeat (3) @(posedge clk_i);
    chk(knockdown_o, 0);
    dtx <= 0; repeat (3) @(posedge clk_i);
    chk(knockdown_o, 1);
    want <= 7'h00; settle();
    chk(knockdown_o, 0);
  endtask
  task automatic t_minor();
    wb(1, `ADDR_IRQ_MASK, 32'h0000_0002); mnr <= 1; want <= 7'h18; settle();
    chk({minor_line_o, disabled_o, irq_o}, 3'b111);
    chk(channel_o, 4'h3);
    mnr <= 0; want <= 7'h00; settle();
    chk({minor_line_o, disabled_o, irq_o}, 3'b001);
    wb(1, `ADDR_IRQ_STAT, 32'h0000_0002); chk(irq_o, 0);
  endtask
  task automatic t_major();
    wb(1, `ADDR_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      pulses = 0; maj <= 1; repeat (3) @(posedge clk_i);
      maj <= 0; repeat (3) @(posedge clk_i);
      chk(pulses, i < 2);
      chk(locked_o, i == 2);
      chk(major_line_o, i == 2);
    end
    chk({disabled_o, irq_o}, 2'b11);
    wb(0, `ADDR_STAT, 0); chk(q[0], 1);
    pulses = 0; wb(1, `ADDR_STAT, 32'h0000_0001); repeat (3) @(posedge clk_i);
    chk(pulses, 1);
    chk({locked_o, major_line_o, disabled_o}, 0);
    wb(0, 8'h40, 0); chk(q, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, `ADDR_POL, 0); chk(q, 0);
    chk({major_line_o, minor_line_o, irq_o}, 0);
    t_lines();
    t_pol();
    t_knock();
    t_minor();
    t_major();
    results();
  end
endmodule
